// *** bench/s16_mem_model.sv ***
// far-side unified memory emulator with variable answer delay
`timescale 1ns/10ps
module s16_mem_model (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // request side
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output logic      [15:0] mem_rdata,
   output logic             mem_ack,
   // answer pace
   input  wire logic        slow
);
   logic [15:0] mem [0:65535];
   logic [1:0]  wait_q;
   initial mem_rdata = 16'h0000;
   initial mem_ack = 1'b0;
   always @(posedge sys_clk)
   begin
      mem_ack   <= 1'b0;
      // toggles between answers so stale data never looks valid
      mem_rdata <= ~mem_rdata;
      if (srst)
         wait_q <= 2'h0;
      else if (mem_req && !mem_ack)
      begin
         if (wait_q == 2'h0)
         begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem[mem_addr];
            if (mem_we)
               mem[mem_addr] <= mem_wdata;
            wait_q <= slow ? 2'($urandom % 4) : 2'h0;
         end
         else
            wait_q <= wait_q - 2'h1;
      end
   end
endmodule

// *** bench/testbench.sv ***
// self-checking bench: programs in external memory, stores and apb compared
`timescale 1ns/10ps
module testbench;
   logic        sys_clk = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic        mem_event = 1'b0;
   logic        serial_event = 1'b0;
   logic        slow = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        mem_req;
   logic        mem_we;
   logic [15:0] mem_addr;
   logic [15:0] mem_wdata;
   logic [15:0] mem_rdata;
   logic        mem_ack;
   int          fails = 0;
   int          n_tests = 0;
   int          cyc = 0;
   logic [31:0] sq[$];
   logic [64:0] aq[$];
   logic [15:0] prog[$];
   logic [15:0] rv [0:7];
   logic        ev;
   logic        zf;
   logic        gt;
   logic        eq;
   logic [15:0] end_pc;

   s16_core u_dut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
      .mem_event, .serial_event);
   s16_mem_model u_mem (.sys_clk, .srst, .mem_req, .mem_we, .mem_addr, .mem_wdata,
      .mem_rdata, .mem_ack, .slow);

   always #2 sys_clk = ~sys_clk;

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk_mem(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: memory got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_apb(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: apb got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic void emit(input logic [15:0] w);
      prog.push_back(w);
   endfunction

   function automatic void ldi(input logic [2:0] o, input logic [8:0] v);
      emit({v, o, 4'h7});
      if (o != 3'h0)
         rv[o] = {7'h00, v};
   endfunction

   function automatic void setf(input logic [15:0] r, input logic [15:0] a, input logic [15:0] b);
      zf = (r == 16'h0000);
      gt = (a > b);
      eq = (a == b);
   endfunction

   function automatic void alu(input logic [2:0] s, input logic [2:0] o);
      logic [15:0] r;
      case (s)
         3'h0: r = rv[1] + rv[2];
         3'h1: r = rv[1] - rv[2];
         3'h2: r = rv[1][7:0] * rv[2][7:0];
         default: r = ~(rv[1] & rv[2]);
      endcase
      emit({o, 3'h2, 3'h1, s, 4'h1});
      setf(r, rv[1], rv[2]);
      rv[o] = r;
   endfunction

   function automatic void st(input logic [2:0] r2, input logic [15:0] a, input logic on);
      emit({3'h0, r2, 6'h00, 4'h6});
      emit(a);
      if (on)
         sq.push_back({a, rv[r2]});
   endfunction

   function automatic void build();
      logic [15:0] p;
      logic [7:0]  l;
      logic [2:0]  s;
      logic        tk;
      prog.delete();
      sq.delete();
      for (int i = 0; i < 8; i++)
         rv[i] = 16'h0000;
      emit({12'($urandom), 4'h0});
      ldi(3'h0, 9'h1FF);
      st(3'h0, 16'h4000, 1'b1);
      ldi(3'h1, 9'($urandom));
      ldi(3'h2, 9'($urandom));
      for (int k = 0; k < 4; k++)
      begin
         alu(3'(k), 3'h3);
         st(3'h3, 16'h4001 + 16'(k), 1'b1);
      end
      for (int k = 0; k < 2; k++)
      begin
         ldi(3'h4, 9'($urandom));
         l = 8'($urandom);
         emit({l, 3'h4, 1'(k), 4'h2});
         rv[4] = (k == 0) ? rv[4] + 16'(l) : rv[4] * 16'(l);
         st(3'h4, 16'h4010 + 16'(k), 1'b1);
      end
      u_mem.mem[16'h5000] = 16'($urandom);
      emit(16'hA005);
      emit(16'h5000);
      rv[5] = u_mem.mem[16'h5000];
      st(3'h5, 16'h4020, 1'b1);
      ldi(3'h6, 9'h1E0);
      u_mem.mem[16'h01E0] = 16'($urandom);
      emit({3'h5, 3'h0, 3'h6, 3'h1, 4'h5});
      rv[5] = u_mem.mem[16'h01E0];
      st(3'h5, 16'h4021, 1'b1);
      ldi(3'h6, 9'h1E8);
      emit({3'h0, 3'h1, 3'h6, 3'h1, 4'h6});
      sq.push_back({16'h01E8, rv[1]});
      for (int k = 0; k < 16; k++)
      begin
         s = 3'(k);
         ldi(3'h1, 9'($urandom % 3));
         ldi(3'h2, 9'($urandom % 3));
         alu(3'h1, 3'h3);
         ldi(3'h5, 9'(k));
         p = 16'(prog.size());
         if (s != 3'h6)
         begin
            ldi(3'h6, 9'(p + 16'h4));
            emit({6'h00, 3'h6, s, 4'h4});
         end
         else
         begin
            emit(16'h0064);
            emit(p + 16'h4);
         end
         case (s)
            3'h1: tk = zf;
            3'h2: tk = gt;
            3'h3: tk = !gt;
            3'h4, 3'h5: tk = ev;
            3'h7: tk = eq;
            default: tk = 1'b1;
         endcase
         // data kept clear of the reserved word 769
         st(3'h5, 16'h4100 + 16'(k), !tk);
      end
      p = 16'(prog.size());
      ldi(3'h6, 9'(p + 16'h1));
      emit(16'h0304);
      end_pc = p + 16'h1;
      for (int i = 0; i < prog.size(); i++)
         u_mem.mem[i] = prog[i];
   endfunction

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [31:0] e, input logic er);
      aq.push_back({er, m, e});
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   always @(posedge sys_clk)
   begin
      if (!srst && mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1)
      begin
         if (sq.size() == 0)
            chk_mem({mem_addr, mem_wdata}, 32'hFFFFFFFF);
         else
            chk_mem({mem_addr, mem_wdata}, sq.pop_front());
      end
   end

   always @(posedge sys_clk)
   begin
      logic [64:0] e;
      if (!srst && pready === 1'b1)
      begin
         e = (aq.size() == 0) ? 65'h0 : aq.pop_front();
         chk_apb(prdata & e[63:32], e[31:0]);
         chk_apb({31'h0, pslverr}, {31'h0, e[64]});
      end
   end

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         fails++;
         complete_run();
      end
   end

   initial
   begin
      void'($urandom(32'h859A));
      for (int run = 0; run < 2; run++)
      begin
         ev = 1'(run);
         slow <= 1'(run);
         build();
         srst <= 1'b1;
         repeat (8) @(posedge sys_clk);
         srst <= 1'b0;
         @(posedge sys_clk);
         while (mem_req !== 1'b1)
            @(posedge sys_clk);
         chk_mem({16'h0000, mem_addr}, 32'h00000000);
         mem_event <= ev;
         serial_event <= ev;
         @(posedge sys_clk);
         mem_event <= 1'b0;
         serial_event <= 1'b0;
         while (sq.size() != 0)
            @(posedge sys_clk);
         repeat (30) @(posedge sys_clk);
         apb(1'b0, 8'h00, 32'h0, 32'h1, 32'h1, 1'b0);
         apb(1'b0, 8'h08, 32'h0, 32'h18, ev ? 32'h18 : 32'h0, 1'b0);
         apb(1'b1, 8'h08, 32'h8, 32'h0, 32'h0, 1'b0);
         apb(1'b0, 8'h08, 32'h0, 32'h18, ev ? 32'h10 : 32'h0, 1'b0);
         apb(1'b0, 8'h04, 32'h0, 32'h18FFFF, {11'h0, ev, 4'h0, end_pc}, 1'b0);
         apb(1'b0, 8'h0C, 32'h0, 32'h0, 32'h0, 1'b1);
         apb(1'b1, 8'h0C, 32'h5, 32'h0, 32'h0, 1'b1);
         // stopping the core must leave the memory bus idle
         apb(1'b1, 8'h00, 32'h0, 32'h0, 32'h0, 1'b0);
         apb(1'b0, 8'h00, 32'h0, 32'h1, 32'h0, 1'b0);
         repeat (10) @(posedge sys_clk);
         chk_mem({31'h0, mem_req}, 32'h00000000);
         apb(1'b1, 8'h00, 32'h1, 32'h0, 32'h0, 1'b0);
      end
      complete_run();
   end
endmodule

// *** verilog/s16_core.sv ***
// 16-bit processor core with external unified memory and apb control
`timescale 1ns/10ps
module s16_core #(
   parameter int ADDR_W  = 16,
   parameter int NUM_GPR = 6
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // external memory
   output logic             mem_req,
   output logic             mem_we,
   output logic      [15:0] mem_addr,
   output logic      [15:0] mem_wdata,
   input  wire logic [15:0] mem_rdata,
   input  wire logic        mem_ack,
   // event inputs
   input  wire logic        mem_event,
   input  wire logic        serial_event
);
   if (ADDR_W != 16 || NUM_GPR != 6)
   begin : g_chk
      $error("s16_core supports only a 16-bit address and six registers");
   end

   s16_pkg::s16_state_t state_q, state_d;
   logic [15:0]         pc_q, pc_d, ir_q, ir_d, addr_d, wdata_d, wr_data, alu_res;
   logic [15:0]         mem_addr_q, mem_wdata_q;
   logic [15:0]         gpr_q [0:7];
   logic                req_d, we_d, mem_req_q, mem_we_q, run_q, wr_en, flag_upd;
   logic                zero_flag, greater_flag, equal_flag;
   logic                memory_event_flag, serial_event_flag;
   logic [4:0]          flags;
   logic [2:0]          wr_idx;
   logic [31:0]         prdata_q;
   logic                pready_q, pslverr_q;

   // instruction fields
   wire [3:0]  opc               = ir_q[3:0];
   wire [2:0]  set3              = ir_q[6:4];
   wire        set1              = ir_q[4];
   wire [2:0]  r1_idx            = ir_q[9:7];
   wire [2:0]  r2_idx            = ir_q[12:10];
   wire [2:0]  ro_idx            = ir_q[15:13];
   wire [2:0]  lit_ro            = ir_q[6:4];
   wire [2:0]  imm_ro            = ir_q[7:5];
   wire [8:0]  nine_bit_literal  = ir_q[15:7];
   wire [7:0]  eight_bit_literal = ir_q[15:8];
   wire [15:0] op_a              = gpr_q[r1_idx];
   wire [15:0] op_b              = gpr_q[r2_idx];
   wire [15:0] op_i              = gpr_q[imm_ro];
   wire [15:0] cmp_a             = (opc == s16_pkg::OP_ALU) ? op_a : op_i;
   wire [15:0] cmp_b             = (opc == s16_pkg::OP_ALU) ? op_b : {8'h00, eight_bit_literal};
   wire [15:0] pc_next           = pc_q + 16'h0001;
   wire        st_fetch          = (state_q == s16_pkg::ST_FETCH);
   wire        st_exec           = (state_q == s16_pkg::ST_EXEC);
   wire        mem_done          = mem_req_q && mem_ack;

   assign flags = {serial_event_flag, memory_event_flag, equal_flag, greater_flag, zero_flag};

   // register slots: zero register, six general, flag register
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_reg
         if (gi == 0)
         begin : g_zero
            assign gpr_q[gi] = 16'h0000;
         end
         else if (gi == 7)
         begin : g_flag
            assign gpr_q[gi] = {11'h000, flags};
         end
         else
         begin : g_gpr
            always_ff @(posedge sys_clk)
            begin
               if (srst)
                  gpr_q[gi] <= 16'h0000;
               else if (wr_en && wr_idx == 3'(gi))
                  gpr_q[gi] <= wr_data;
            end
         end
      end
   endgenerate

   // branch condition per settings
   function automatic logic br_cond(input logic [2:0] s, input logic [4:0] f);
      case (s)
         s16_pkg::BR_ALW:  return 1'b1;
         s16_pkg::BR_ZERO: return f[s16_pkg::FLG_ZERO];
         s16_pkg::BR_GT:   return f[s16_pkg::FLG_GT];
         s16_pkg::BR_NGT:  return !f[s16_pkg::FLG_GT];
         s16_pkg::BR_MEM:  return f[s16_pkg::FLG_MEM];
         s16_pkg::BR_SER:  return f[s16_pkg::FLG_SER];
         s16_pkg::BR_EQ:   return f[s16_pkg::FLG_EQ];
         default:          return 1'b0;
      endcase
   endfunction

   wire br_take = br_cond(set3, flags);

   // alu; shift settings have no defined amount and leave the destination alone
   always_comb
   begin
      alu_res = 16'h0000;
      if (opc == s16_pkg::OP_IMM)
         alu_res = set1 ? 16'(op_i * eight_bit_literal)
                        : op_i + {8'h00, eight_bit_literal};
      else
         case (set3)
            s16_pkg::ALU_ADD:  alu_res = op_a + op_b;
            s16_pkg::ALU_SUB:  alu_res = op_a - op_b;
            s16_pkg::ALU_MUL:  alu_res = op_a[7:0] * op_b[7:0];
            s16_pkg::ALU_NAND: alu_res = ~(op_a & op_b);
            default:           alu_res = 16'h0000;
         endcase
   end

   wire alu_known = (opc == s16_pkg::OP_IMM) || (set3 <= s16_pkg::ALU_NAND);

   // sequencer: ext and data raise req once, fetch raises it once only while run_q is set; each waits for ack
   always_comb
   begin
      state_d  = state_q;
      pc_d     = pc_q;
      ir_d     = ir_q;
      req_d    = mem_req_q;
      we_d     = mem_we_q;
      addr_d   = mem_addr_q;
      wdata_d  = mem_wdata_q;
      wr_en    = 1'b0;
      wr_idx   = ro_idx;
      wr_data  = alu_res;
      flag_upd = 1'b0;
      case (state_q)
         s16_pkg::ST_FETCH:
         begin
            if (mem_done)
            begin
               req_d   = 1'b0;
               ir_d    = mem_rdata;
               state_d = s16_pkg::ST_EXEC;
            end
            else if (!mem_req_q && run_q)
            begin
               req_d  = 1'b1;
               we_d   = 1'b0;
               addr_d = pc_q;
            end
         end
         s16_pkg::ST_EXEC:
         begin
            state_d = s16_pkg::ST_FETCH;
            pc_d    = pc_next;
            case (opc)
               s16_pkg::OP_ALU, s16_pkg::OP_IMM:
               begin
                  wr_en    = alu_known;
                  wr_idx   = (opc == s16_pkg::OP_ALU) ? ro_idx : imm_ro;
                  flag_upd = 1'b1;
               end
               s16_pkg::OP_LIT:
               begin
                  wr_en   = 1'b1;
                  wr_idx  = lit_ro;
                  wr_data = {7'h00, nine_bit_literal};
               end
               s16_pkg::OP_BR:
               begin
                  if (set3 == s16_pkg::BR_IMM)
                  begin
                     state_d = s16_pkg::ST_EXT;
                     addr_d  = pc_next;
                     we_d    = 1'b0;
                  end
                  else if (br_take)
                     pc_d = op_a;
               end
               s16_pkg::OP_LOAD, s16_pkg::OP_STORE:
               begin
                  wdata_d = op_b;
                  if (set1)
                  begin
                     state_d = s16_pkg::ST_DATA;
                     addr_d  = op_a;
                     we_d    = (opc == s16_pkg::OP_STORE);
                  end
                  else
                  begin
                     state_d = s16_pkg::ST_EXT;
                     addr_d  = pc_next;
                     we_d    = 1'b0;
                     pc_d    = pc_q + 16'h0002;
                  end
               end
               default: pc_d = pc_next;
            endcase
         end
         s16_pkg::ST_EXT:
         begin
            if (mem_done)
            begin
               req_d = 1'b0;
               if (opc == s16_pkg::OP_BR)
               begin
                  pc_d    = mem_rdata;
                  state_d = s16_pkg::ST_FETCH;
               end
               else
               begin
                  addr_d  = mem_rdata;
                  we_d    = (opc == s16_pkg::OP_STORE);
                  state_d = s16_pkg::ST_DATA;
               end
            end
            else if (!mem_req_q)
               req_d = 1'b1;
         end
         s16_pkg::ST_DATA:
         begin
            if (mem_done)
            begin
               req_d   = 1'b0;
               we_d    = 1'b0;
               state_d = s16_pkg::ST_FETCH;
               wr_en   = (opc == s16_pkg::OP_LOAD);
               wr_data = mem_rdata;
            end
            else if (!mem_req_q)
               req_d = 1'b1;
         end
         default:
         begin
            state_d = s16_pkg::ST_FETCH;
            req_d   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_q     <= s16_pkg::ST_FETCH;
         pc_q        <= s16_pkg::PC_RST;
         ir_q        <= 16'h0000;
         mem_req_q   <= 1'b0;
         mem_we_q    <= 1'b0;
         mem_addr_q  <= 16'h0000;
         mem_wdata_q <= 16'h0000;
      end
      else
      begin
         state_q     <= state_d;
         pc_q        <= pc_d;
         ir_q        <= ir_d;
         mem_req_q   <= req_d;
         mem_we_q    <= we_d;
         mem_addr_q  <= addr_d;
         mem_wdata_q <= wdata_d;
      end
   end

   // apb: one wait state, pready registered
   wire        apb_acc    = psel && penable && !pready_q;
   wire        apb_done   = psel && penable && pready_q;
   wire        sel_ctrl   = (paddr == s16_pkg::ADDR_CTRL);
   wire        sel_status = (paddr == s16_pkg::ADDR_STATUS);
   wire        sel_flags  = (paddr == s16_pkg::ADDR_FLAGS);
   wire        apb_map    = sel_ctrl || sel_status || sel_flags;
   wire        apb_wr     = apb_done && pwrite && !pslverr_q;
   wire        clr_mem    = apb_wr && sel_flags && pwdata[s16_pkg::FLG_MEM];
   wire        clr_ser    = apb_wr && sel_flags && pwdata[s16_pkg::FLG_SER];
   wire [31:0] rd_mux     = sel_ctrl   ? {31'h00000000, run_q} :
                            sel_status ? {11'h000, flags, pc_q} :
                            sel_flags  ? {27'h0000000, flags} : 32'h00000000;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
         run_q     <= s16_pkg::RUN_RST;
      end
      else
      begin
         pready_q  <= apb_acc;
         pslverr_q <= apb_acc && !apb_map;
         prdata_q  <= (apb_acc && !pwrite) ? rd_mux : 32'h00000000;
         if (apb_wr && sel_ctrl)
            run_q <= pwdata[0];
      end
   end

   // flags; an event in the clearing cycle wins over the clear
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         zero_flag         <= 1'b0;
         greater_flag      <= 1'b0;
         equal_flag        <= 1'b0;
         memory_event_flag <= 1'b0;
         serial_event_flag <= 1'b0;
      end
      else
      begin
         if (flag_upd)
         begin
            zero_flag    <= (alu_res == 16'h0000);
            greater_flag <= (cmp_a > cmp_b);
            equal_flag   <= (cmp_a == cmp_b);
         end
         memory_event_flag <= mem_event || (memory_event_flag && !clr_mem);
         serial_event_flag <= serial_event || (serial_event_flag && !clr_ser);
      end
   end

   assign mem_req   = mem_req_q;
   assign mem_we    = mem_we_q;
   assign mem_addr  = mem_addr_q;
   assign mem_wdata = mem_wdata_q;
   assign prdata    = prdata_q;
   assign pready    = pready_q;
   assign pslverr   = pslverr_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   fetch_addr_a: assert property (st_fetch && mem_req_q
      |-> mem_addr_q == pc_q && !mem_we_q) else $error("fetch address differs from pc");
   req_hold_a: assert property (mem_req_q && !mem_ack
      |=> mem_req_q && $stable(mem_addr_q)) else $error("memory request dropped before ack");
   reset_start_a: assert property ($fell(srst) |-> pc_q == 16'h0000 && st_fetch)
      else $error("core not at address zero after reset");
   nop_step_a: assert property (st_exec && opc == s16_pkg::OP_NOP
      |=> pc_q == $past(pc_q) + 16'h0001 && st_fetch) else $error("no-op step wrong");
   lit_load_a: assert property (st_exec && opc == s16_pkg::OP_LIT && lit_ro == 3'h1
      |=> gpr_q[1] == {7'h00, $past(nine_bit_literal)}) else $error("literal load wrong");
   add_res_a: assert property (st_exec && opc == s16_pkg::OP_ALU
      && set3 == s16_pkg::ALU_ADD && ro_idx == 3'h3 |=> gpr_q[3] == $past(op_a) + $past(op_b))
      else $error("add result wrong");
   zero_skip_a: assert property (st_exec && opc == s16_pkg::OP_BR
      && set3 == s16_pkg::BR_ZERO && !zero_flag |=> pc_q == $past(pc_q) + 16'h0001)
      else $error("branch on zero taken while flag clear");
   gt_taken_a: assert property (st_exec && opc == s16_pkg::OP_BR
      && set3 == s16_pkg::BR_GT && greater_flag |=> pc_q == $past(op_a))
      else $error("branch on greater not taken");
   store_reg_a: assert property (st_exec && opc == s16_pkg::OP_STORE && set1
      |=> mem_addr_q == $past(op_a) ##1 mem_req_q && mem_we_q && mem_wdata_q == $past(op_b, 2))
      else $error("register store address or data wrong");
   apb_wait_a: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
      else $error("apb answer not a single cycle");
   event_set_a: assert property (mem_event |=> memory_event_flag)
      else $error("memory event lost");
endmodule

// *** verilog/s16_pkg.sv ***
// constants and types shared by the 16-bit core
package s16_pkg;
   // opcodes, low nibble of each instruction word
   localparam logic [3:0] OP_NOP   = 4'h0;
   localparam logic [3:0] OP_ALU   = 4'h1;
   localparam logic [3:0] OP_IMM   = 4'h2;
   localparam logic [3:0] OP_BR    = 4'h4;
   localparam logic [3:0] OP_LOAD  = 4'h5;
   localparam logic [3:0] OP_STORE = 4'h6;
   localparam logic [3:0] OP_LIT   = 4'h7;
   // alu settings
   localparam logic [2:0] ALU_ADD  = 3'h0;
   localparam logic [2:0] ALU_SUB  = 3'h1;
   localparam logic [2:0] ALU_MUL  = 3'h2;
   localparam logic [2:0] ALU_NAND = 3'h3;
   // branch settings
   localparam logic [2:0] BR_ALW   = 3'h0;
   localparam logic [2:0] BR_ZERO  = 3'h1;
   localparam logic [2:0] BR_GT    = 3'h2;
   localparam logic [2:0] BR_NGT   = 3'h3;
   localparam logic [2:0] BR_MEM   = 3'h4;
   localparam logic [2:0] BR_SER   = 3'h5;
   localparam logic [2:0] BR_IMM   = 3'h6;
   localparam logic [2:0] BR_EQ    = 3'h7;
   // register slots
   localparam logic [2:0] REG_ZERO  = 3'h0;
   localparam logic [2:0] REG_FLAGS = 3'h7;
   // flag word bit positions
   localparam int FLG_ZERO = 0;
   localparam int FLG_GT   = 1;
   localparam int FLG_EQ   = 2;
   localparam int FLG_MEM  = 3;
   localparam int FLG_SER  = 4;
   // apb map
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_FLAGS  = 8'h08;
   // reset values
   localparam logic        RUN_RST = 1'b1;
   localparam logic [15:0] PC_RST  = 16'h0000;
   typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_EXT, ST_DATA} s16_state_t;
endpackage
